// ===== logic/wdpm_map.svh
// register map, field positions, reset values and timing counts
`ifndef WDPM_MAP_SVH
`define WDPM_MAP_SVH

`define WDPM_ADDR_W        12
`define WDPM_OFS_CTRL      12'h000
`define WDPM_OFS_PERIOD    12'h004
`define WDPM_OFS_CAUSE     12'h008
`define WDPM_OFS_IRQ_STAT  12'h00C
`define WDPM_OFS_IRQ_MASK  12'h010
`define WDPM_OFS_STATUS    12'h014
`define WDPM_OFS_COUNT     12'h018
`define WDPM_OFS_IFT       12'h01C

`define WDPM_CTRL_ON       15
`define WDPM_CTRL_SERVICE  0
`define WDPM_CFG_WD_EN     23

`define WDPM_CAUSE_TIMEOUT 4
`define WDPM_CAUSE_SLEEP   3
`define WDPM_CAUSE_IDLE    2
`define WDPM_CAUSE_MASK    32'h0000001C

`define WDPM_IRQ_NMI       0
`define WDPM_IRQ_RESET     1
`define WDPM_IRQ_WAKE      2
`define WDPM_IRQ_W         3

`define WDPM_PERIOD_RST    32'h0000FFFF
`define WDPM_MASK_RST      3'h0
`define WDPM_BOOT_CYCLES   2'h3

`endif

// ===== logic/wdpm_pkg.sv
// types shared by the watchdog power-mode block
package wdpm_pkg;

	typedef enum logic [1:0] {
		st_boot,
		st_start_delay,
		st_run
	} wdpm_state_type;

endpackage

// ===== logic/wdpm_sync.sv
// two flip-flop synchroniser for pin levels
`timescale 1ns/1ps
module wdpm_sync #(
	parameter int WIDTH = 1
) (
	// clock and reset
	input  wire logic             pclk,
	input  wire logic             presetn,
	// levels
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);

	logic [WIDTH-1:0] stage1;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			stage1   <= '0;
			sync_out <= '0;
		end else begin
			stage1   <= async_in;
			sync_out <= stage1;
		end
	end

endmodule

// ===== logic/wdpm_top.sv
// watchdog power-mode, debug and reset behaviour with apb registers
//
// Implementation choices: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
`include "wdpm_map.svh"
module wdpm_top
	import wdpm_pkg::*;
#(
	parameter int HAS_REGULATOR    = 1,
	parameter int OSC_START_CYCLES = 1000,
	parameter int POWERUP_DELAY_TIMER_CYCLES      = 5000
) (
	// clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// apb slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// pins
	input  wire logic        regulator_control_pin,
	input  wire logic [31:0] device_config_word,
	// core and power manager
	input  wire logic        sleep_mode,
	input  wire logic        idle_mode,
	input  wire logic        debug_mode,
	input  wire logic        other_wake,
	input  wire logic        fetch_strobe,
	// results
	output logic             wake_nmi,
	output logic             wd_device_reset,
	output logic             cpu_run,
	output logic             irq
);

	logic [1:0]     pin_sync;
	logic           reg_pin;
	logic           cfg_wd_en;
	logic           powerup_delay_timer_enabled;
	wdpm_state_type state;
	logic [1:0]     boot_count;
	logic [31:0]    delay_left;
	logic [31:0]    wake_delay;
	logic           wd_on;
	logic [31:0]    period;
	logic [31:0]    wd_count;
	logic [31:0]    ift_count;
	logic [31:0]    cause;
	logic [2:0]     irq_stat;
	logic [2:0]     irq_mask;
	logic [2:0]     irq_set;
	logic [2:0]     next_irq_stat;
	logic [31:0]    cause_set;
	logic [31:0]    next_cause;
	logic           wd_tick;
	logic           expire;
	logic           expire_sleep;
	logic           expire_idle;
	logic           expire_awake;
	logic           foreign_wake;
	logic           wr_en;
	logic           setup;
	logic           addr_ok;
	logic [31:0]    rd_value;
	logic           service;

	wdpm_sync #(
		.WIDTH(2)
	) u_pin_sync (
		.pclk    (pclk),
		.presetn (presetn),
		.async_in({regulator_control_pin,
			device_config_word[`WDPM_CFG_WD_EN]}),
		.sync_out(pin_sync)
	);

	assign reg_pin   = pin_sync[1];
	assign cfg_wd_en = pin_sync[0];

	// pin high keeps the regulator on
	always_comb begin
		if (HAS_REGULATOR == 0) begin
			powerup_delay_timer_enabled = 1'b1;
		end else begin
			powerup_delay_timer_enabled = !reg_pin;
		end
	end

	// apb decode
	assign setup   = psel && !penable;
	assign wr_en   = psel && penable && pwrite && pready && !pslverr;
	assign addr_ok = (paddr[11:5] == 7'h00) && (paddr[1:0] == 2'h0);
	assign service = wr_en && (paddr == `WDPM_OFS_CTRL)
		&& pwdata[`WDPM_CTRL_SERVICE];

	// watchdog events
	assign wd_tick      = wd_on && !debug_mode;
	assign expire       = wd_tick && (wd_count >= period);
	assign expire_sleep = expire && sleep_mode;
	assign expire_idle  = expire && idle_mode && !sleep_mode;
	assign expire_awake = expire && !sleep_mode && !idle_mode;
	assign foreign_wake = other_wake && (sleep_mode || idle_mode);

	always_comb begin
		wake_delay = 32'(OSC_START_CYCLES);
		if (powerup_delay_timer_enabled) begin
			wake_delay = 32'(OSC_START_CYCLES + POWERUP_DELAY_TIMER_CYCLES);
		end
	end

	// start-up sequencing and execution gate
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state      <= st_boot;
			boot_count <= 2'h0;
			delay_left <= 32'h00000000;
			cpu_run    <= 1'b0;
		end else begin
			case (state)
				st_boot: begin
					boot_count <= boot_count + 2'h1;
					if (boot_count == `WDPM_BOOT_CYCLES - 2'h1) begin
						if (powerup_delay_timer_enabled) begin
							state      <= st_start_delay;
							delay_left <= 32'(POWERUP_DELAY_TIMER_CYCLES);
						end else begin
							state   <= st_run;
							cpu_run <= 1'b1;
						end
					end
				end
				st_start_delay: begin
					if (delay_left <= 32'h00000001) begin
						state   <= st_run;
						cpu_run <= 1'b1;
					end else begin
						delay_left <= delay_left - 32'h00000001;
					end
				end
				st_run: begin
					if (expire_sleep) begin
						state      <= st_start_delay;
						delay_left <= wake_delay;
						cpu_run    <= 1'b0;
					end
					// idle wake keeps cpu_run high
				end
				default: begin
					state   <= st_boot;
					cpu_run <= 1'b0;
				end
			endcase
		end
	end

	// control register on bit
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wd_on <= 1'b0;
		end else if (state == st_boot
			&& boot_count == `WDPM_BOOT_CYCLES - 2'h1) begin
			wd_on <= cfg_wd_en;
		end else if (wr_en && paddr == `WDPM_OFS_CTRL) begin
			wd_on <= pwdata[`WDPM_CTRL_ON];
		end
	end

	// period register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			period <= `WDPM_PERIOD_RST;
		end else if (wr_en && paddr == `WDPM_OFS_PERIOD) begin
			period <= pwdata;
		end
	end

	// watchdog count
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wd_count <= 32'h00000000;
		end else if (foreign_wake) begin
			wd_count <= 32'h00000000;
		end else if (service || expire) begin
			wd_count <= 32'h00000000;
		end else if (wd_tick) begin
			wd_count <= wd_count + 32'h00000001;
		end
	end

	// instruction-fetch timer
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ift_count <= 32'h00000000;
		end else if (wr_en && paddr == `WDPM_OFS_IFT) begin
			ift_count <= 32'h00000000;
		end else if (fetch_strobe && !sleep_mode && !idle_mode) begin
			ift_count <= ift_count + 32'h00000001;
		end
	end

	// wake and reset outputs
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wake_nmi        <= 1'b0;
			wd_device_reset <= 1'b0;
		end else begin
			wake_nmi        <= expire_sleep || expire_idle;
			wd_device_reset <= expire_awake;
		end
	end

	// cause flags, set wins over clear
	always_comb begin
		cause_set = 32'h00000000;
		if (expire) begin
			cause_set[`WDPM_CAUSE_TIMEOUT] = 1'b1;
		end
		if (expire_sleep) begin
			cause_set[`WDPM_CAUSE_SLEEP] = 1'b1;
		end
		if (expire_idle) begin
			cause_set[`WDPM_CAUSE_IDLE] = 1'b1;
		end
		next_cause = cause;
		if (wr_en && paddr == `WDPM_OFS_CAUSE) begin
			next_cause = cause & ~(pwdata & `WDPM_CAUSE_MASK);
		end
		next_cause = next_cause | cause_set;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cause <= 32'h00000000;
		end else begin
			cause <= next_cause;
		end
	end

	// interrupt status and mask
	always_comb begin
		irq_set                 = 3'h0;
		irq_set[`WDPM_IRQ_NMI]   = expire_sleep || expire_idle;
		irq_set[`WDPM_IRQ_RESET] = expire_awake;
		irq_set[`WDPM_IRQ_WAKE]  = foreign_wake;
		next_irq_stat = irq_stat;
		if (wr_en && paddr == `WDPM_OFS_IRQ_STAT) begin
			next_irq_stat = irq_stat & ~pwdata[`WDPM_IRQ_W-1:0];
		end
		next_irq_stat = next_irq_stat | irq_set;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_stat <= 3'h0;
			irq      <= 1'b0;
		end else begin
			irq_stat <= next_irq_stat;
			irq      <= |(next_irq_stat & irq_mask);
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_mask <= `WDPM_MASK_RST;
		end else if (wr_en && paddr == `WDPM_OFS_IRQ_MASK) begin
			irq_mask <= pwdata[`WDPM_IRQ_W-1:0];
		end
	end

	// read mux
	always_comb begin
		rd_value = 32'h00000000;
		case (paddr)
			`WDPM_OFS_CTRL: begin
				rd_value[`WDPM_CTRL_ON] = wd_on;
			end
			`WDPM_OFS_PERIOD: begin
				rd_value = period;
			end
			`WDPM_OFS_CAUSE: begin
				rd_value = cause;
			end
			`WDPM_OFS_IRQ_STAT: begin
				rd_value[`WDPM_IRQ_W-1:0] = irq_stat;
			end
			`WDPM_OFS_IRQ_MASK: begin
				rd_value[`WDPM_IRQ_W-1:0] = irq_mask;
			end
			`WDPM_OFS_STATUS: begin
				rd_value[4:0] = {idle_mode, sleep_mode, debug_mode,
					powerup_delay_timer_enabled, cpu_run};
			end
			`WDPM_OFS_COUNT: begin
				rd_value = wd_count;
			end
			`WDPM_OFS_IFT: begin
				rd_value = ift_count;
			end
			default: begin
				rd_value = 32'h00000000;
			end
		endcase
	end

	// apb answer one cycle after setup
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h00000000;
		end else if (setup) begin
			pready  <= 1'b1;
			pslverr <= !addr_ok;
			prdata  <= (addr_ok && !pwrite) ? rd_value : 32'h00000000;
		end else begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h00000000;
		end
	end

endmodule

// ===== test/wdpm_monitor.sv
// port assertions for the watchdog power-mode block
`timescale 1ns/1ps
module wdpm_monitor (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb
	input wire logic psel,
	input wire logic penable,
	input wire logic pready,
	input wire logic pslverr,
	// power manager and results
	input wire logic sleep_mode,
	input wire logic idle_mode,
	input wire logic debug_mode,
	input wire logic wake_nmi,
	input wire logic wd_device_reset,
	input wire logic cpu_run
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence stall_seq;
		!cpu_run [*4];
	endsequence
	sequence ready_seq;
		pready ##1 !pready;
	endsequence
	chk_nmi_saving: assert property (
		wake_nmi |-> $past(sleep_mode | idle_mode)) else $error("nmi awake");
	chk_reset_awake: assert property (
		wd_device_reset |-> !$past(sleep_mode) && !$past(idle_mode))
		else $error("reset in saving");
	chk_debug_hold: assert property (
		(wake_nmi || wd_device_reset) |-> !$past(debug_mode))
		else $error("expiry in debug");
	chk_sleep_delay: assert property (
		wake_nmi && $past(sleep_mode) |-> stall_seq ##[1:20] cpu_run)
		else $error("sleep wake delay");
	chk_idle_nodelay: assert property (
		wake_nmi && !$past(sleep_mode) |-> cpu_run [*3])
		else $error("idle wake delay");
	chk_nmi_pulse: assert property (
		wake_nmi |=> !wake_nmi) else $error("nmi not a pulse");
	chk_ready_once: assert property (
		psel && !penable |=> ready_seq) else $error("pready timing");
	chk_err_ready: assert property (
		pslverr |-> pready) else $error("pslverr alone");
endmodule

// ===== test/wdpm_power_model.sv
// core and power manager model: enters and leaves power saving
`timescale 1ns/1ps
module wdpm_power_model (
	// clock and reset
	input  wire logic       pclk,
	input  wire logic       presetn,
	// mode request: 1 sleep, 2 idle, 3 awake
	input  wire logic [1:0] cmd,
	input  wire logic       wake_nmi,
	// levels
	output logic            sleep_mode,
	output logic            idle_mode
);
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sleep_mode <= 1'b0;
			idle_mode  <= 1'b0;
		end else if (wake_nmi) begin
			sleep_mode <= 1'b0;
			idle_mode  <= 1'b0;
		end else if (cmd != 2'h0) begin
			sleep_mode <= (cmd == 2'h1);
			idle_mode  <= (cmd == 2'h2);
		end
	end
endmodule

// ===== test/wdpm_tb.sv
// self-checking bench for the watchdog power-mode block
`timescale 1ns/1ps
`include "wdpm_map.svh"
`define CHK(nm, e, s) begin n_compared++; if ((s) !== (e)) begin \
	n_mismatch++; $display("[FAIL] %s exp %h got %h", nm, e, s); end end
module wdpm_tb;
	logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, cfg = 32'h0, prdata;
	logic        reg_pin = 1, debug_mode = 0, other_wake = 0, fetch = 0;
	logic        pready, pslverr, sleep_mode, idle_mode, wake_nmi;
	logic        wd_device_reset, cpu_run, irq, cpu_run2;
	logic [1:0]  cmd = 2'h0;
	logic [32:0] exp_q[$], note;
	int          n_mismatch = 0, n_compared = 0, seed = 50, n_pulse = 0, n0;
	always #10 pclk = ~pclk;
	wdpm_top #(.HAS_REGULATOR(1), .OSC_START_CYCLES(4), .POWERUP_DELAY_TIMER_CYCLES(8))
	dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .regulator_control_pin(reg_pin),
		.device_config_word(cfg), .sleep_mode(sleep_mode),
		.idle_mode(idle_mode), .debug_mode(debug_mode),
		.other_wake(other_wake), .fetch_strobe(fetch), .wake_nmi(wake_nmi),
		.wd_device_reset(wd_device_reset), .cpu_run(cpu_run), .irq(irq));
	// variant without internal regulator
	wdpm_top #(.HAS_REGULATOR(0), .OSC_START_CYCLES(4), .POWERUP_DELAY_TIMER_CYCLES(8))
	dut_u2 (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(),
		.pready(), .pslverr(), .regulator_control_pin(reg_pin),
		.device_config_word(cfg), .sleep_mode(sleep_mode),
		.idle_mode(idle_mode), .debug_mode(debug_mode),
		.other_wake(other_wake), .fetch_strobe(fetch), .wake_nmi(),
		.wd_device_reset(), .cpu_run(cpu_run2), .irq());
	wdpm_power_model pm_u (.pclk(pclk), .presetn(presetn), .cmd(cmd),
		.wake_nmi(wake_nmi), .sleep_mode(sleep_mode), .idle_mode(idle_mode));
	// read results against the oldest note
	always @(posedge pclk) begin
		if (wake_nmi || wd_device_reset)
			n_pulse++;
		if (psel && penable && pready && !pwrite && exp_q.size() > 0) begin
			note = exp_q.pop_front();
			`CHK("prdata", note, {pslverr, prdata})
		end
	end
	task final_report;
		if (n_mismatch == 0 && n_compared > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int i;
		@(posedge pclk);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk) penable <= 1;
		for (i = 0; i < 50; i++) begin
			@(posedge pclk);
			if (pready === 1'b1)
				break;
		end
		if (i == 50) begin
			n_mismatch++;
			final_report;
		end
		psel <= 0;
		penable <= 0;
	endtask
	task rd(input logic [11:0] a, input logic [32:0] e);
		exp_q.push_back(e);
		apb(1'b0, a, 32'h0);
	endtask
	function logic hit(input int k);
		return k == 0 ? wake_nmi === 1'b1 : k == 1 ? wd_device_reset === 1'b1
			: cpu_run === 1'b1;
	endfunction
	task wait_on(input int k);
		int i;
		for (i = 0; i < 400; i++) begin
			@(posedge pclk);
			#1;
			if (hit(k))
				break;
		end
		if (i == 400) begin
			n_mismatch++;
			final_report;
		end
	endtask
	task set_mode(input logic [1:0] m);
		@(posedge pclk) cmd <= m;
		@(posedge pclk) cmd <= 2'h0;
	endtask
	task do_reset(input logic pin, input logic en);
		@(posedge pclk);
		presetn <= 0;
		reg_pin <= pin;
		cfg <= ($random(seed) & 32'hFF7FFFFF) | {8'h00, en, 23'h0};
		repeat (8) @(posedge pclk);
		presetn <= 1;
		repeat (6) @(posedge pclk);
		#1 `CHK("cpu_run", pin, cpu_run)
		`CHK("cpu_run no regulator", 1'b0, cpu_run2)
		wait_on(2);
	endtask
	initial begin
		do_reset(1'b1, 1'b0);
		rd(`WDPM_OFS_CTRL, 33'h0);
		rd(`WDPM_OFS_PERIOD, {1'b0, `WDPM_PERIOD_RST});
		rd(`WDPM_OFS_COUNT, 33'h0);
		rd(`WDPM_OFS_STATUS, 33'h1);
		apb(1'b1, 12'h024, $random(seed));
		rd(12'h020, 33'h100000000);
		rd(`WDPM_OFS_IRQ_MASK, 33'h0);
		repeat (5) begin
			@(posedge pclk) fetch <= 1;
			@(posedge pclk) fetch <= 0;
		end
		set_mode(2'h1);
		repeat (5) begin
			@(posedge pclk) fetch <= 1;
			@(posedge pclk) fetch <= 0;
		end
		set_mode(2'h3);
		rd(`WDPM_OFS_IFT, 33'h5);
		do_reset(1'b0, 1'b1);
		rd(`WDPM_OFS_CTRL, 33'h00008000);
		rd(`WDPM_OFS_STATUS, 33'h3);
		apb(1'b1, `WDPM_OFS_IRQ_MASK, 32'h7);
		apb(1'b1, `WDPM_OFS_PERIOD, 32'd200);
		apb(1'b1, `WDPM_OFS_CTRL, 32'h00008001);
		set_mode(2'h1);
		wait_on(0);
		wait_on(2);
		rd(`WDPM_OFS_CAUSE, 33'h18);
		#1 `CHK("irq", 1'b1, irq)
		rd(`WDPM_OFS_PERIOD, 33'd200);
		apb(1'b1, `WDPM_OFS_CAUSE, `WDPM_CAUSE_MASK);
		apb(1'b1, `WDPM_OFS_IRQ_STAT, 32'h7);
		repeat (2) @(posedge pclk);
		#1 `CHK("irq", 1'b0, irq)
		set_mode(2'h2);
		wait_on(0);
		rd(`WDPM_OFS_CAUSE, 33'h14);
		apb(1'b1, `WDPM_OFS_CAUSE, `WDPM_CAUSE_MASK);
		wait_on(1);
		rd(`WDPM_OFS_CAUSE, 33'h10);
		rd(`WDPM_OFS_IRQ_STAT, 33'h3);
		apb(1'b1, `WDPM_OFS_CTRL, 32'h00008001);
		debug_mode <= 1;
		n0 = n_pulse;
		repeat (300) @(posedge pclk);
		`CHK("debug pulses", n0, n_pulse)
		debug_mode <= 0;
		set_mode(2'h1);
		repeat (150) @(posedge pclk);
		other_wake <= 1;
		@(posedge pclk) other_wake <= 0;
		set_mode(2'h3);
		n0 = n_pulse;
		repeat (150) @(posedge pclk);
		`CHK("early expiry", n0, n_pulse)
		final_report;
	end
endmodule
bind wdpm_top wdpm_monitor mon_u (.pclk(pclk), .presetn(presetn),
	.psel(psel), .penable(penable), .pready(pready), .pslverr(pslverr),
	.sleep_mode(sleep_mode), .idle_mode(idle_mode), .debug_mode(debug_mode),
	.wake_nmi(wake_nmi), .wd_device_reset(wd_device_reset),
	.cpu_run(cpu_run));
